// ---- shared/pmss_pkg.sv ----
package pmss_pkg;
    // timebase: one tick per timing-element unit
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned TICK_US         = 10;
    localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
    // timing-element value in nanofarads, default 22 nF
    localparam int unsigned CSD_NF          = 22;
    // intervals in ticks derived from one element (/1000 for nF to uF)
    // cutoff period = 1 / (0.64 / C) s = C / 0.64 s
    localparam int unsigned CUTOFF_US       = CSD_NF * 1000 / 640 * 1000;
    localparam int unsigned CUTOFF_TICKS    = CUTOFF_US / TICK_US;
    // constraint = 30.5 * 1.57 * C s
    localparam int unsigned CONSTR_US       = CSD_NF * 30500 / 1000 * 1570;
    localparam int unsigned CONSTR_TICKS    = CONSTR_US / TICK_US;
    // masking = 6.5 * 1.57 * C s
    localparam int unsigned MASK_US         = CSD_NF * 6500 / 1000 * 1570;
    localparam int unsigned MASK_TICKS      = MASK_US / TICK_US;
    // initial reset = 0.13 * C s, must exceed the minimum
    localparam int unsigned RESET_US        = CSD_NF * 130;
    localparam int unsigned RESET_MIN_US    = 100;
    localparam int unsigned RESET_TICKS     =
        ((RESET_US > RESET_MIN_US) ? RESET_US : RESET_MIN_US + 1) / TICK_US
        + 1;
    // intermittent drive burst length while the clock is cut
    localparam int unsigned BURST_TICKS     = RESET_TICKS * 4;
    localparam int unsigned CNT_W           = 24;
    // current limit thresholds in millivolts
    localparam logic [9:0]  ILIM_ACCEL_MV   = 10'h24E;
    localparam logic [9:0]  ILIM_DECEL_MV   = 10'h172;
    localparam int unsigned ERR_W           = 16;
    typedef enum logic [1:0] {
        PMSS_DRV_OFF,
        PMSS_DRV_ACCEL,
        PMSS_DRV_BRAKE
    } pmss_drive_e;
endpackage

// ---- hdl/pmss_interval.sv ----
`timescale 1ns/10ps
module pmss_interval #(
    parameter int unsigned W     = 24,
    parameter int unsigned LIMIT = 16
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_clear,
    input  wire logic i_tick,
    output logic      o_expired
);
    logic [W-1:0] count;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= '0;
        end else if (i_clear) begin
            count <= '0;
        end else if (i_tick && count != W'(LIMIT)) begin
            count <= count + W'(1);
        end
    end

    // saturates so expiry is a level until cleared
    assign o_expired = (count == W'(LIMIT));
endmodule

// ---- hdl/pmss_core.sv ----
// What this block does
// - phase error from reference falling edge to feedback rising edge
// - regulate feedback frequency equal to reference, no division
// - reverse-torque brake whenever the motor must slow down
// - stop mode cuts all drive, motor coasts without braking
// - stopped means power save; regulator output stays available
// - feedback pulse comes from the first hall phase input
// - reference below cutoff frequency forces intermittent drive
// - start with no clock: brief drive, then off for good
// - clock returning before constraint time resumes drive
// - no feedback edge within constraint time turns drive off
// - constraint shutdown latched until stop or power cycle
// - lock glitches masked; lock output delayed by masking time
// - logic held in reset on start until timing node threshold
// - initial reset longer than the required minimum
// - higher current limit accelerating, lower decelerating
// - option: constraint never trips; initial reset and clock cutoff still work
`timescale 1ns/10ps
module pmss_core #(
    parameter int unsigned TICK_CYCLES   = pmss_pkg::TICK_CYC,
    parameter int unsigned CUTOFF_LIMIT  = pmss_pkg::CUTOFF_TICKS,
    parameter int unsigned CONSTR_LIMIT  = pmss_pkg::CONSTR_TICKS,
    parameter int unsigned MASK_LIMIT    = pmss_pkg::MASK_TICKS,
    parameter int unsigned RESET_LIMIT   = pmss_pkg::RESET_TICKS,
    parameter int unsigned BURST_LIMIT   = pmss_pkg::BURST_TICKS
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_b,
    input  wire logic                     i_start,
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_hall_phase_one_input,
    input  wire logic                     i_protect_disable,
    output logic                          o_drive_enable,
    output pmss_pkg::pmss_drive_e         o_drive_mode,
    output logic signed [pmss_pkg::ERR_W-1:0] o_phase_error,
    output logic [9:0]                    o_current_sense_limit_mv,
    output logic                          o_speed_feedback_pulse,
    output logic                          o_lock,
    output logic                          o_power_save,
    output logic                          o_regulator_output_en,
    output logic                          o_constraint_latched,
    output logic                          o_intermittent
);
    import pmss_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // timebase and edge detection
    logic [CNT_W-1:0] tick_cnt;
    logic             tick;
    logic             ref_d;
    logic             hall_d;
    logic             ref_fall;
    logic             fb_rise;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == CNT_W'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + CNT_W'(1);
            tick     <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_d  <= 1'b0;
            hall_d <= 1'b0;
        end else begin
            ref_d  <= i_ref_clk;
            hall_d <= i_hall_phase_one_input;
        end
    end

    assign ref_fall = ref_d && !i_ref_clk;
    assign fb_rise  = !hall_d && i_hall_phase_one_input;

    ////////////////////////////////////////////////////////////////////////
    // initial reset after start
    logic running;
    logic start_d;
    logic init_clear;
    logic init_done;
    logic enter_start;

    assign enter_start = i_start && !start_d;
    assign init_clear  = !i_start;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            start_d <= 1'b0;
        end else begin
            start_d <= i_start;
        end
    end

    // limit is derived so the hold always beats the minimum
    pmss_interval #(.W(CNT_W), .LIMIT(RESET_LIMIT)) u_init (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_clear   (init_clear),
        .i_tick    (tick),
        .o_expired (init_done)
    );

    assign running = i_start && init_done;

    ////////////////////////////////////////////////////////////////////////
    // clock cutoff, constraint, masking intervals
    logic cutoff;
    logic constr_exp;
    logic mask_done;
    logic burst_done;
    logic locked_raw;
    logic mask_clear;
    logic constr_latch;
    logic next_constr_latch;

    pmss_interval #(.W(CNT_W), .LIMIT(CUTOFF_LIMIT)) u_cutoff (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_clear   (ref_fall || !running),
        .i_tick    (tick),
        .o_expired (cutoff)
    );

    pmss_interval #(.W(CNT_W), .LIMIT(CONSTR_LIMIT)) u_constr (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_clear   (fb_rise || !running),
        .i_tick    (tick),
        .o_expired (constr_exp)
    );

    // burst restarts on each reference falling edge, so drive pulses only while the reference still toggles
    pmss_interval #(.W(CNT_W), .LIMIT(BURST_LIMIT)) u_burst (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_clear   (!cutoff || ref_fall),
        .i_tick    (tick),
        .o_expired (burst_done)
    );

    assign mask_clear = !locked_raw || !running;

    pmss_interval #(.W(CNT_W), .LIMIT(MASK_LIMIT)) u_mask (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_clear   (mask_clear),
        .i_tick    (tick),
        .o_expired (mask_done)
    );

    // external option removes the trip entirely, initial reset stays
    assign next_constr_latch = !i_start ? 1'b0 :
        (constr_latch || (constr_exp && running && !i_protect_disable));

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            constr_latch <= 1'b0;
        end else begin
            constr_latch <= next_constr_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase detector: signed ref-to-feedback distance in cycles
    logic signed [ERR_W-1:0] err_cnt;
    logic signed [ERR_W-1:0] err;
    logic                    ref_seen;
    logic                    fb_seen;
    logic signed [ERR_W-1:0] err_max;
    logic signed [ERR_W-1:0] err_min;

    assign err_max = {1'b0, {(ERR_W-1){1'b1}}};
    assign err_min = {1'b1, {(ERR_W-1){1'b0}}};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_cnt  <= '0;
            err      <= '0;
            ref_seen <= 1'b0;
            fb_seen  <= 1'b0;
        end else if (!running || (ref_fall && fb_rise)) begin
            err_cnt  <= '0;
            err      <= '0;
            ref_seen <= 1'b0;
            fb_seen  <= 1'b0;
        end else if (ref_fall) begin
            // feedback late: positive error means speed up
            if (fb_seen) begin
                err      <= err_cnt;
                fb_seen  <= 1'b0;
                err_cnt  <= '0;
            end else begin
                ref_seen <= 1'b1;
                err_cnt  <= '0;
            end
        end else if (fb_rise) begin
            if (ref_seen) begin
                err      <= err_cnt;
                ref_seen <= 1'b0;
                err_cnt  <= '0;
            end else begin
                fb_seen  <= 1'b1;
                err_cnt  <= '0;
            end
        end else if (ref_seen && err_cnt != err_max) begin
            err_cnt <= err_cnt + ERR_W'(1);
        end else if (fb_seen && err_cnt != err_min) begin
            err_cnt <= err_cnt - ERR_W'(1);
        end
    end

    // one-to-one edge pairing, so lock is at f_fb == f_ref
    assign locked_raw = (err == '0) && !ref_seen && !fb_seen;

    ////////////////////////////////////////////////////////////////////////
    // drive decision
    logic        drive_ok;
    logic        slow_down;
    pmss_drive_e next_mode;

    assign drive_ok  = running && !constr_latch && (!cutoff || !burst_done);
    assign slow_down = (err < 0) || fb_seen;

    assign next_mode = !drive_ok ? PMSS_DRV_OFF :
        (slow_down ? PMSS_DRV_BRAKE : PMSS_DRV_ACCEL);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_drive_enable           <= 1'b0;
            o_drive_mode             <= PMSS_DRV_OFF;
            o_phase_error            <= '0;
            o_current_sense_limit_mv <= ILIM_ACCEL_MV;
            o_speed_feedback_pulse   <= 1'b0;
            o_lock                   <= 1'b0;
            o_power_save             <= 1'b1;
            o_regulator_output_en    <= 1'b1;
            o_constraint_latched     <= 1'b0;
            o_intermittent           <= 1'b0;
        end else begin
            o_drive_enable           <= drive_ok;
            o_drive_mode             <= next_mode;
            o_phase_error            <= err;
            o_current_sense_limit_mv <= (next_mode == PMSS_DRV_BRAKE) ?
                ILIM_DECEL_MV : ILIM_ACCEL_MV;
            o_speed_feedback_pulse   <= hall_d;
            o_lock                   <= mask_done && locked_raw;
            o_power_save             <= !i_start;
            o_regulator_output_en    <= 1'b1;
            o_constraint_latched     <= constr_latch;
            o_intermittent           <= running && cutoff;
        end
    end

    // start edge unused, the init hold clears on !i_start; kept for clarity of reset
    logic unused_start;
    assign unused_start = enter_start;
endmodule

// ---- testbench/pmss_core_asserts.sv ----
`timescale 1ns/10ps
module pmss_core_asserts #(
    parameter int unsigned TICK_CYCLES = 2,
    parameter int unsigned MASK_LIMIT  = 10
) (
    input wire logic                  i_clk,
    input wire logic                  i_rst_b,
    input wire logic                  i_start,
    input wire logic                  i_hall_phase_one_input,
    input wire logic                  i_protect_disable,
    input wire logic                  o_drive_enable,
    input wire pmss_pkg::pmss_drive_e o_drive_mode,
    input wire logic signed [pmss_pkg::ERR_W-1:0] o_phase_error,
    input wire logic [9:0]            o_current_sense_limit_mv,
    input wire logic                  o_speed_feedback_pulse,
    input wire logic                  o_lock,
    input wire logic                  o_power_save,
    input wire logic                  o_regulator_output_en,
    input wire logic                  o_constraint_latched,
    input wire logic                  o_intermittent
);
    import pmss_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////
    // cycles of zero error; saturates so a long lock cannot wrap it
    logic [15:0] zcnt;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            zcnt <= 16'h0000;
        else if (o_phase_error != '0)
            zcnt <= 16'h0000;
        else if (!(&zcnt))
            zcnt <= zcnt + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    chk_regulator_kept: assert property (o_regulator_output_en)
        else $error("regulator output dropped");
    chk_stop_coasts: assert property ((!i_start) [*3] |->
        !o_drive_enable && o_drive_mode == PMSS_DRV_OFF && o_power_save)
        else $error("drive or bias left on in stop");
    chk_save_run: assert property (i_start [*3] |-> !o_power_save)
        else $error("power save while started");
    chk_hall_feedback: assert property ($past(i_rst_b, 2) |->
        o_speed_feedback_pulse == $past(i_hall_phase_one_input, 2))
        else $error("feedback pulse not from hall phase one");
    chk_brake_limit: assert property (o_drive_mode == PMSS_DRV_BRAKE &&
        $past(o_drive_mode) == PMSS_DRV_BRAKE |->
        o_current_sense_limit_mv == ILIM_DECEL_MV)
        else $error("wrong limit while braking");
    chk_accel_limit: assert property (
        o_drive_mode != PMSS_DRV_BRAKE |->
        o_current_sense_limit_mv == ILIM_ACCEL_MV)
        else $error("wrong limit outside braking");
    chk_latch_cuts: assert property (o_constraint_latched &&
        $past(o_constraint_latched) |-> !o_drive_enable)
        else $error("drive on while latched");
    chk_latch_holds: assert property (o_constraint_latched &&
        i_start && $past(i_start) |=> o_constraint_latched)
        else $error("latch released while started");
    chk_protect_off: assert property (i_protect_disable &&
        $past(i_protect_disable) && !o_constraint_latched
        |=> !o_constraint_latched)
        else $error("latch tripped with protection off");
    chk_init_hold: assert property ($rose(i_start) |->
        (!o_drive_enable) [*6])
        else $error("drive before initial reset ended");
    chk_lock_masked: assert property ($rose(o_lock) |->
        zcnt >= (MASK_LIMIT - 1) * TICK_CYCLES)
        else $error("lock shown before masking time");
    cover property ($rose(o_lock));
    cover property ($rose(o_constraint_latched));
    cover property ($rose(o_intermittent));
    cover property (o_drive_mode == PMSS_DRV_BRAKE);
endmodule

bind pmss_core pmss_core_asserts #(
    .TICK_CYCLES(TICK_CYCLES),
    .MASK_LIMIT (MASK_LIMIT)
) i_chk (.i_clk, .i_rst_b, .i_start, .i_hall_phase_one_input,
    .i_protect_disable, .o_drive_enable, .o_drive_mode, .o_phase_error,
    .o_current_sense_limit_mv, .o_speed_feedback_pulse, .o_lock,
    .o_power_save, .o_regulator_output_en, .o_constraint_latched,
    .o_intermittent);

// ---- testbench/pmss_motor_model.sv ----
`timescale 1ns/10ps
module pmss_motor_model (
    input  wire logic       i_clk,
    input  wire logic       i_ref_on,
    input  wire logic       i_hall_on,
    input  wire logic [7:0] i_period,
    input  wire logic [7:0] i_lag,
    output logic            o_ref_clk,
    output logic            o_hall
);
    logic [7:0] cnt = 8'h00;
    logic [7:0] ph;
    // hall wave phase; a lag above half a period means the rotor leads
    assign ph = (cnt + i_period - i_lag) % i_period;
    always @(posedge i_clk) begin
        cnt <= #1 (cnt + 8'h01 >= i_period) ? 8'h00 : cnt + 8'h01;
    end
    // lost clock stands high: no falling edge, no glitches
    assign o_ref_clk = i_ref_on ? (cnt >= i_period / 2) : 1'b1;
    // a stalled rotor drives the hall output low
    assign o_hall = i_hall_on ? (ph < i_period / 2) : 1'b0;
endmodule

// ---- testbench/polygon_motor_speed_supervisor_bench.sv ----
`timescale 1ns/10ps
module polygon_motor_speed_supervisor_bench;
    import pmss_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, start = 1'b0, prot = 1'b0;
    logic       ref_on = 1'b1, hall_on = 1'b1, chk_req = 1'b0;
    logic [7:0] per = 8'h10, lag = 8'h00;
    logic       ref_clk, hall, en, fb, lock, ps, reg_en, lat, inter;
    logic [9:0] lim;
    logic [8:0] obs;
    logic [17:0] notes[$];
    logic signed [ERR_W-1:0] err;
    pmss_drive_e mode;
    int         errors = 0, comparisons = 0;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk = ~clk;
    end
    pmss_motor_model i_motor (.i_clk(clk), .i_ref_on(ref_on),
        .i_hall_on(hall_on), .i_period(per), .i_lag(lag),
        .o_ref_clk(ref_clk), .o_hall(hall));
    // short counts keep the run small; all checks scale from these
    // init hold keeps its derived length so the full 0.13 * C hold is exercised
    pmss_core #(.TICK_CYCLES(2), .CUTOFF_LIMIT(20), .CONSTR_LIMIT(60),
        .MASK_LIMIT(10), .BURST_LIMIT(5)) i_dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_start(start),
        .i_ref_clk(ref_clk), .i_hall_phase_one_input(hall),
        .i_protect_disable(prot), .o_drive_enable(en), .o_drive_mode(mode),
        .o_phase_error(err), .o_current_sense_limit_mv(lim),
        .o_speed_feedback_pulse(fb), .o_lock(lock), .o_power_save(ps),
        .o_regulator_output_en(reg_en), .o_constraint_latched(lat),
        .o_intermittent(inter));
    assign obs = {en, mode, ps, lat, inter, lock, err > 0, err < 0};
    ////////////////////////////////////////////////////////////////////////
    // compare the oldest note with the outputs; only masked bits count
    always @(posedge clk) begin
        if (chk_req === 1'b1) begin
            comparisons++;
            if (((obs ^ notes[0][8:0]) & notes[0][17:9]) !== 9'h000) begin
                errors++;
                $display("BAD %0t exp %h got %h", $time, notes[0][8:0], obs);
            end
            void'(notes.pop_front());
        end
    end
    task automatic note(input logic [8:0] m, input logic [8:0] x);
        notes.push_back({m, x});
        chk_req = 1'b1;
        @(posedge clk) #1;
        chk_req = 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h25166A93));
        cyc(4);
        rst_b = 1'b1;
        cyc(2);
        note(9'h1FF, 9'h020);
        start = 1'b1;
        cyc(2);
        note(9'h100, 9'h000);
        cyc(556);
        note(9'h100, 9'h000);
        for (int k = 0; k < 3; k++) begin
            // hall held off for a period so a reference edge leads
            hall_on = 1'b0;
            per = 8'(12 + 2 * ($urandom % 7));
            lag = 8'(2 + $urandom % 3);
            cyc(26);
            hall_on = 1'b1;
            cyc(274);
            note(9'h1FF, 9'h142);
            // reference held off so a feedback edge leads into braking
            ref_on = 1'b0;
            lag = per - 8'(2 + $urandom % 3);
            cyc(26);
            ref_on = 1'b1;
            cyc(274);
            note(9'h1FF, 9'h181);
        end
        lag = 8'h00;
        cyc(12);
        note(9'h004, 9'h000);
        cyc(300);
        note(9'h13F, 9'h104);
        ref_on = 1'b0;
        cyc(120);
        note(9'h038, 9'h008);
        hall_on = 1'b0;
        ref_on = 1'b1;
        lag = 8'h03;
        cyc(26);
        hall_on = 1'b1;
        cyc(274);
        note(9'h1FF, 9'h142);
        hall_on = 1'b0;
        cyc(200);
        note(9'h130, 9'h010);
        hall_on = 1'b1;
        cyc(100);
        note(9'h130, 9'h010);
        start = 1'b0;
        cyc(5);
        note(9'h1FF, 9'h020);
        ref_on = 1'b0;
        hall_on = 1'b0;
        start = 1'b1;
        cyc(800);
        note(9'h130, 9'h010);
        ref_on = 1'b1;
        hall_on = 1'b1;
        cyc(200);
        note(9'h130, 9'h010);
        start = 1'b0;
        cyc(5);
        prot = 1'b1;
        hall_on = 1'b0;
        cyc(2);
        start = 1'b1;
        cyc(800);
        note(9'h030, 9'h000);
        test_done();
    end
endmodule
